//--- flash_target_model.sv
// Code flash and register target model for the decoder's far side
`timescale 1ns/1ps
module flash_target_model (
	// Flash byte port
	input  wire logic [19:0] flash_addr,
	output logic      [7:0]  flash_rdata,
	// Register and RAM targets
	input  wire logic [19:0] target_addr,
	output logic      [7:0]  target_rdata
);
	// Pattern differs per byte and per bank, so a wrong bank shows
	function automatic logic [7:0] fbyte(input logic [19:0] a);
		return a[7:0] ^ a[15:8] ^ {a[16], 7'h35};
	endfunction : fbyte
	function automatic logic [7:0] tbyte(input logic [19:0] a);
		return ~a[7:0] ^ a[15:8];
	endfunction : tbyte
	// Two flash bytes always pair to a target below 10000H
	assign flash_rdata  = fbyte(flash_addr);
	assign target_rdata = tbyte(target_addr);
endmodule : flash_target_model

//--- memory_space_decoder.sv
// Memory space decoder: region decode, mirror window and vector reads
`timescale 1ns/1ps
`include "memory_space_decoder_defs.svh"

module memory_space_decoder
	import memory_space_decoder_pkg::*;
#(
	parameter int FLASH_BYTES = 131072,
	parameter int NUM_SOURCES = 64
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Boot swap selection
	input  wire logic        boot_swap,
	// CPU access request
	input  wire logic        acc_valid,
	input  wire logic [19:0] acc_addr,
	input  wire logic        acc_fetch,
	input  wire logic        acc_write,
	input  wire logic [7:0]  acc_wdata,
	input  wire logic [7:0]  acc_bit_mask,
	// CPU access answer
	output logic             acc_done,
	output logic      [7:0]  acc_rdata,
	output logic             acc_error,
	// Vector request
	input  wire logic        vec_req,
	input  wire logic [5:0]  vec_source,
	input  wire logic        vec_table_call_instruction,
	output logic             vec_done,
	output logic      [19:0] vec_target,
	// Flash read port
	output logic             flash_rd,
	output logic      [19:0] flash_addr,
	input  wire logic [7:0]  flash_rdata,
	// Other target strobes
	output logic             ram_sel,
	output logic             gpr_sel,
	output logic             sfr_sel,
	output logic             xsfr_sel,
	output logic      [19:0] target_addr,
	output logic             target_write,
	output logic      [7:0]  target_wdata,
	input  wire logic [7:0]  target_rdata,
	// Status
	output logic             mirror_bank_bit,
	output region_e          acc_region,
	output flash_area_e      acc_area
);

	initial begin
		if (NUM_SOURCES < 1 || NUM_SOURCES > 64)
			$error("NUM_SOURCES must lie in 1..64");
	end

	region_e     region;
	flash_area_e area;
	logic [7:0]  mirror_sel;
	logic        pend;
	logic        pend_flash;
	logic        pend_local;
	logic [19:0] vf_rd_addr;
	logic        vf_rd_en;
	logic [19:0] vf_target;
	logic        vf_done;

	region_classifier #(
		.FLASH_BYTES (FLASH_BYTES)
	) u_classifier (
		.addr        (acc_addr),
		.region      (region),
		.area        (area)
	);

	// Vector entry address: reset shares entry zero, swap moves the table
	wire [19:0] table_base = vec_table_call_instruction ?
		(boot_swap ? `TABLE_CALL_INSTRUCTION_SWAP_BASE : `TABLE_CALL_INSTRUCTION_BASE) :
		(boot_swap ? `VEC_SWAP_BASE : `VEC_BASE);
	wire [19:0] entry_off  = {13'h0000, vec_source, 1'b0};
	wire [19:0] entry_addr = table_base + entry_off;

	vector_fetcher u_vector (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.start      (vec_req),
		.entry_addr (entry_addr),
		.rd_addr    (vf_rd_addr),
		.rd_en      (vf_rd_en),
		.rd_data    (flash_rdata),
		.target     (vf_target),
		.done       (vf_done)
	);

	// Request classification
	wire is_mirror_reg = acc_addr == `MIRROR_SEL_ADDR;
	wire mirror_ok     = region == REGION_MIRROR && !acc_fetch
	                     && !acc_write;
	wire flash_ok      = region == REGION_FLASH && !acc_write;
	wire ram_ok        = region == REGION_RAM;
	wire gpr_ok        = region == REGION_GPR && !acc_fetch;
	wire sfr_ok        = region == REGION_SFR && !acc_fetch;
	wire xsfr_ok       = region == REGION_XSFR && !acc_fetch;
	wire bad_access    = !(mirror_ok || flash_ok || ram_ok || gpr_ok
	                     || sfr_ok || xsfr_ok);
	wire take          = acc_valid && !pend && !vf_rd_en;

	// Mirror window maps onto the selected bank
	wire [19:0] mirror_flash = {3'b000,
		mirror_sel[`MIRROR_BANK_BIT_POS], acc_addr[15:0]};

	// Bit writes touch only masked bits; byte writes use a full mask
	wire [7:0] next_mirror_sel = ((mirror_sel & ~acc_bit_mask)
		| (acc_wdata & acc_bit_mask)) & 8'h01;

	// Mirror select register, only the bank bit is implemented
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			mirror_sel <= `MIRROR_SEL_RESET;
		else if (take && acc_write && is_mirror_reg)
			mirror_sel <= next_mirror_sel;
	end

	// Access sequencing: registered decode, answer one cycle later
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pend       <= 1'b0;
			pend_flash <= 1'b0;
			pend_local <= 1'b0;
		end else begin
			pend       <= take;
			pend_flash <= take && (mirror_ok || flash_ok);
			pend_local <= take && is_mirror_reg;
		end
	end

	// Strobes to memories and peripherals
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ram_sel      <= 1'b0;
			gpr_sel      <= 1'b0;
			sfr_sel      <= 1'b0;
			xsfr_sel     <= 1'b0;
			target_addr  <= 20'h00000;
			target_write <= 1'b0;
			target_wdata <= 8'h00;
			acc_region   <= REGION_NONE;
			acc_area     <= AREA_CODE;
		end else begin
			ram_sel      <= take && ram_ok;
			gpr_sel      <= take && gpr_ok;
			sfr_sel      <= take && sfr_ok && !is_mirror_reg;
			xsfr_sel     <= take && xsfr_ok;
			target_write <= take && acc_write && !bad_access;
			if (take) begin
				target_addr  <= acc_addr;
				target_wdata <= acc_wdata;
				acc_region   <= region;
				acc_area     <= area;
			end
		end
	end

	// Flash port shared between vector reads and CPU reads
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			flash_rd   <= 1'b0;
			flash_addr <= 20'h00000;
		end else if (vf_rd_en) begin
			flash_rd   <= 1'b1;
			flash_addr <= vf_rd_addr;
		end else if (take && (mirror_ok || flash_ok)) begin
			flash_rd   <= 1'b1;
			flash_addr <= mirror_ok ? mirror_flash : acc_addr;
		end else begin
			flash_rd   <= 1'b0;
		end
	end

	// Answer to the CPU, error on fetch, write or unmapped read where not served
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			acc_done  <= 1'b0;
			acc_rdata <= 8'h00;
			acc_error <= 1'b0;
		end else begin
			acc_done <= pend;
			if (pend)
				acc_rdata <= pend_local ? mirror_sel :
				             pend_flash ? flash_rdata : target_rdata;
			if (take)
				acc_error <= bad_access;
			else if (pend)
				acc_error <= acc_error;
			else
				acc_error <= 1'b0;
		end
	end

	// Vector results and the visible bank selection
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			vec_done        <= 1'b0;
			vec_target      <= 20'h00000;
			mirror_bank_bit <= 1'b0;
		end else begin
			vec_done        <= vf_done;
			mirror_bank_bit <= mirror_sel[`MIRROR_BANK_BIT_POS];
			if (vf_done)
				vec_target <= vf_target;
		end
	end

endmodule : memory_space_decoder

//--- memory_space_decoder_defs.svh
// Address map constants for the memory space decoder
`ifndef MEMORY_SPACE_DECODER_DEFS_SVH
`define MEMORY_SPACE_DECODER_DEFS_SVH

`define ADDR_W               20
`define VEC_BASE             20'h00000
`define VEC_LAST             20'h0007f
`define VEC_SWAP_BASE        20'h01000
`define TABLE_CALL_INSTRUCTION_BASE           20'h00080
`define TABLE_CALL_INSTRUCTION_LAST           20'h000bf
`define TABLE_CALL_INSTRUCTION_SWAP_BASE      20'h01080
`define OPT_BASE             20'h000c0
`define OPT_LAST             20'h000c3
`define OPT_SWAP_BASE        20'h010c0
`define SECID_BASE           20'h000c4
`define SECID_LAST           20'h000cd
`define SECID_SWAP_BASE      20'h010c4
`define SWAP_OFFSET          20'h01000
`define MIRROR_BASE          20'hf0000
`define XSFR_BASE            20'hf0000
`define XSFR_LAST            20'hf07ff
`define RAM_BASE             20'hfe900
`define RAM_LAST             20'hffeff
`define GPR_BASE             20'hffee0
`define GPR_LAST             20'hffeff
`define SFR_BASE             20'hfff00
`define SFR_LAST             20'hfffff
`define MIRROR_SEL_ADDR      20'hffffe
`define MIRROR_SEL_RESET     8'h00
`define MIRROR_BANK_BIT_POS  0
`define FLASH_BANK_BIT       16

`endif

//--- memory_space_decoder_pkg.sv
// Types shared by the memory space decoder modules
package memory_space_decoder_pkg;

	typedef enum logic [2:0] {
		REGION_NONE   = 3'b000,
		REGION_FLASH  = 3'b001,
		REGION_MIRROR = 3'b010,
		REGION_XSFR   = 3'b011,
		REGION_RAM    = 3'b100,
		REGION_GPR    = 3'b101,
		REGION_SFR    = 3'b110
	} region_e;

	typedef enum logic [2:0] {
		AREA_CODE   = 3'b000,
		AREA_VECTOR = 3'b001,
		AREA_TABLE_CALL_INSTRUCTION  = 3'b010,
		AREA_OPTION = 3'b011,
		AREA_SECID  = 3'b100
	} flash_area_e;

	typedef enum logic [1:0] {
		VEC_IDLE = 2'b00,
		VEC_LOW  = 2'b01,
		VEC_HIGH = 2'b10,
		VEC_DONE = 2'b11
	} vec_state_e;

endpackage : memory_space_decoder_pkg

//--- memory_space_decoder_props.sv
// Checker of decode, mirror and vector read behaviour
`timescale 1ns/1ps
module memory_space_decoder_props (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        rstn,
	// Requests
	input wire logic        boot_swap,
	input wire logic [19:0] acc_addr,
	input wire logic        acc_fetch,
	input wire logic        acc_write,
	input wire logic        vec_req,
	input wire logic [5:0]  vec_source,
	input wire logic        vec_table_call_instruction,
	// Answers and strobes
	input wire logic        acc_done,
	input wire logic        acc_error,
	input wire logic        vec_done,
	input wire logic [19:0] vec_target,
	input wire logic        flash_rd,
	input wire logic [19:0] flash_addr,
	input wire logic        ram_sel,
	input wire logic        gpr_sel,
	input wire logic        sfr_sel,
	input wire logic        xsfr_sel,
	input wire logic [19:0] target_addr,
	input wire logic        mirror_bank_bit
);
	default clocking dc @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	logic [19:0] pa;
	logic [19:0] vexp;
	wire         up = pa[19:16] == 4'hf;

	// Access address and first entry byte, one cycle late
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			pa   <= 20'h0;
			vexp <= 20'h0;
		end else begin
			pa   <= acc_addr;
			vexp <= (boot_swap ? 20'h01000 : 20'h0)
				+ (vec_table_call_instruction ? 20'h80 : 20'h0) + {13'h0, vec_source, 1'b0};
		end
	end

	AST_MIRROR_MAP: assert property (flash_rd && up |->
		flash_addr == {3'h0, mirror_bank_bit, pa[15:0]})
		else $error("mirror read went to wrong flash byte");
	AST_MIRROR_YIELD: assert property (flash_rd && up |->
		pa inside {[20'hf0800:20'hfe8ff]} && !acc_fetch)
		else $error("mirror served an overridden or fetch access");
	AST_FETCH_REFUSE: assert property (acc_done && acc_fetch && up
		&& pa < 20'hfe900 |-> acc_error)
		else $error("fetch from upper window not refused");
	AST_RAM_OPEN: assert property (acc_done
		&& pa inside {[20'hfe900:20'hffedf]} |-> !acc_error)
		else $error("RAM access refused");
	AST_GPR_SEL: assert property (gpr_sel |->
		target_addr inside {[20'hffee0:20'hffeff]} && !acc_fetch)
		else $error("register bank select out of place");
	AST_SFR_SEL: assert property (sfr_sel |->
		target_addr >= 20'hfff00 && target_addr != 20'hffffe)
		else $error("register select out of place");
	AST_XSFR_SEL: assert property (xsfr_sel |->
		target_addr inside {[20'hf0000:20'hf07ff]})
		else $error("extended register select out of place");
	AST_BANK_CAUSE: assert property ($changed(mirror_bank_bit) |->
		pa == 20'hffffe && acc_write)
		else $error("bank bit changed without its write");
	AST_VEC_ADDR: assert property (vec_req |->
		##[1:2] flash_rd && flash_addr == vexp)
		else $error("entry read at wrong address");
	AST_VEC_PAIR: assert property (flash_rd ##1 flash_rd |->
		flash_addr[0] && $past(flash_addr) == {flash_addr[19:1], 1'b0})
		else $error("entry bytes not even then odd");
	AST_VEC_DONE: assert property (vec_req |->
		##[3:5] vec_done && vec_target[19:16] == 4'h0)
		else $error("entry read late or above 64K");

	COV_VEC: cover property (vec_done && boot_swap && vec_table_call_instruction);
	COV_BANK: cover property (flash_rd && up && mirror_bank_bit);
	COV_REFUSE: cover property (acc_done && acc_error && acc_fetch);
endmodule : memory_space_decoder_props

bind memory_space_decoder memory_space_decoder_props u_props (.sys_clk,
	.rstn, .boot_swap, .acc_addr, .acc_fetch, .acc_write, .vec_req,
	.vec_source, .vec_table_call_instruction, .acc_done, .acc_error, .vec_done, .vec_target,
	.flash_rd, .flash_addr, .ram_sel, .gpr_sel, .sfr_sel, .xsfr_sel,
	.target_addr, .mirror_bank_bit);

//--- region_classifier.sv
// Combinational classification of a 20-bit address into a region
`timescale 1ns/1ps
`include "memory_space_decoder_defs.svh"

module region_classifier
	import memory_space_decoder_pkg::*;
#(
	parameter int FLASH_BYTES = 131072
) (
	// Address under test
	input  wire logic [19:0] addr,
	// Classification
	output region_e          region,
	output flash_area_e      area
);

	initial begin
		if (FLASH_BYTES < 256 || FLASH_BYTES > 131072)
			$error("FLASH_BYTES out of range");
	end

	localparam logic [19:0] FLASH_LAST = 20'(FLASH_BYTES - 1);

	// Low copy or boot swap copy of the reserved areas
	wire [19:0] low_addr   = addr - `SWAP_OFFSET;
	wire        in_swap    = addr >= `SWAP_OFFSET && low_addr <= `SECID_LAST;
	wire [19:0] rsv_addr   = in_swap ? low_addr : addr;

	wire in_sfr   = addr >= `SFR_BASE;
	wire in_gpr   = addr >= `GPR_BASE && addr <= `GPR_LAST;
	wire in_ram   = addr >= `RAM_BASE && addr <= `RAM_LAST;
	wire in_xsfr  = addr >= `XSFR_BASE && addr <= `XSFR_LAST;
	wire in_mir   = addr >= `MIRROR_BASE;
	wire in_flash = addr <= FLASH_LAST;

	// Register and RAM regions override the mirror window
	assign region = in_sfr   ? REGION_SFR :
	                in_gpr   ? REGION_GPR :
	                in_ram   ? REGION_RAM :
	                in_xsfr  ? REGION_XSFR :
	                in_mir   ? REGION_MIRROR :
	                in_flash ? REGION_FLASH : REGION_NONE;

	// Reserved areas at the bottom of flash, and their swap copies
	assign area = !in_flash                  ? AREA_CODE :
	              rsv_addr <= `VEC_LAST      ? AREA_VECTOR :
	              rsv_addr <= `TABLE_CALL_INSTRUCTION_LAST    ? AREA_TABLE_CALL_INSTRUCTION :
	              rsv_addr <= `OPT_LAST      ? AREA_OPTION :
	              rsv_addr <= `SECID_LAST    ? AREA_SECID :
	              AREA_CODE;

endmodule : region_classifier

//--- testbench.sv
// Self-checking bench for the memory space decoder
`timescale 1ns/1ps
module testbench;
	import memory_space_decoder_pkg::*;
	localparam logic [1:0] RD = 2'd0, FE = 2'd1, WR = 2'd2;
	logic sys_clk = 1'b0, rstn, boot_swap, acc_valid;
	logic acc_fetch, acc_write, vec_req;
	logic vec_table_call_instruction, acc_done, acc_error, vec_done, flash_rd;
	logic ram_sel, gpr_sel, sfr_sel, xsfr_sel, target_write, mirror_bank_bit;
	logic [19:0] acc_addr, vec_target, flash_addr, target_addr;
	logic [7:0] acc_wdata, acc_bit_mask;
	logic [7:0] acc_rdata, flash_rdata, target_wdata, target_rdata;
	logic [5:0] vec_source;
	logic [4:0] sn;
	region_e acc_region;
	flash_area_e acc_area;
	int n_fail = 0, num_checks = 0;

	always #12.5 sys_clk = ~sys_clk;

	memory_space_decoder dut (.sys_clk, .rstn, .boot_swap, .acc_valid,
		.acc_addr, .acc_fetch, .acc_write, .acc_wdata, .acc_bit_mask,
		.acc_done, .acc_rdata, .acc_error, .vec_req, .vec_source, .vec_table_call_instruction,
		.vec_done, .vec_target, .flash_rd, .flash_addr, .flash_rdata,
		.ram_sel, .gpr_sel, .sfr_sel, .xsfr_sel, .target_addr, .target_write,
		.target_wdata, .target_rdata, .mirror_bank_bit, .acc_region,
		.acc_area);
	flash_target_model fm (.flash_addr, .flash_rdata, .target_addr,
		.target_rdata);

	task automatic check(input logic [19:0] got, input logic [19:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, got, exp);
		end
	endtask : check

	task automatic final_report;
		if (n_fail == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : final_report

	// One access; fields stay put afterwards so the checker can see them
	task automatic xfer(input logic [19:0] a, input logic [1:0] k,
		input logic [7:0] ed, input logic ee, input logic [4:0] es);
		@(negedge sys_clk);
		{acc_addr, acc_fetch, acc_write} = {a, k[0], k[1]};
		acc_valid = 1'b1;
		@(negedge sys_clk);
		acc_valid = 1'b0;
		sn = {flash_rd, ram_sel, gpr_sel, sfr_sel, xsfr_sel};
		for (int i = 0; i < 8 && acc_done !== 1'b1; i++) begin
			@(posedge sys_clk);
			#1;
			sn |= {flash_rd, ram_sel, gpr_sel, sfr_sel, xsfr_sel};
		end
		if (acc_done !== 1'b1) begin
			n_fail++;
			final_report();
		end
		check(acc_error, ee);
		check(sn, es);
		if (!k[1] && !ee)
			check(acc_rdata, ed);
	endtask : xfer

	task automatic t_regions;
		check(mirror_bank_bit, 1'b0);
		xfer(20'hffffe, RD, 8'h00, 1'b0, 5'h00);
		xfer(20'hf1234, RD, fm.fbyte(20'h01234), 1'b0, 5'h10);
		xfer(20'hf0800, RD, fm.fbyte(20'h00800), 1'b0, 5'h10);
		xfer(20'hfe8ff, RD, fm.fbyte(20'h0e8ff), 1'b0, 5'h10);
		xfer(20'hf07ff, RD, fm.tbyte(20'hf07ff), 1'b0, 5'h01);
		xfer(20'hfe900, RD, fm.tbyte(20'hfe900), 1'b0, 5'h08);
		xfer(20'hffee0, RD, fm.tbyte(20'hffee0), 1'b0, 5'h04);
		xfer(20'hfff10, RD, fm.tbyte(20'hfff10), 1'b0, 5'h02);
	endtask : t_regions

	// Fetches, writes and reserved-area reads that must be refused or served
	task automatic t_fetch;
		xfer(20'hf1234, FE, 8'h00, 1'b1, 5'h00);
		xfer(20'hfe900, FE, fm.tbyte(20'hfe900), 1'b0, 5'h08);
		xfer(20'hffee0, FE, 8'h00, 1'b1, 5'h00);
		xfer(20'h00100, FE, fm.fbyte(20'h00100), 1'b0, 5'h10);
		xfer(20'hf1234, WR, 8'h00, 1'b1, 5'h00);
		xfer(20'h000c4, WR, 8'h00, 1'b1, 5'h00);
		xfer(20'h000c0, RD, fm.fbyte(20'h000c0), 1'b0, 5'h10);
		xfer(20'h010c3, RD, fm.fbyte(20'h010c3), 1'b0, 5'h10);
		xfer(20'h010cd, RD, fm.fbyte(20'h010cd), 1'b0, 5'h10);
	endtask : t_fetch

	// Both tables, normal and swapped, first and last entries
	task automatic t_vectors;
		logic [19:0] a;
		logic [5:0]  s;
		for (int k = 0; k < 8; k++) begin
			s = k[0] ? (k[1] ? 6'd31 : 6'd63) : 6'd0;
			a = (k[2] ? 20'h01000 : 20'h0) + (k[1] ? 20'h80 : 20'h0)
				+ {13'h0, s, 1'b0};
			@(negedge sys_clk);
			{acc_addr, boot_swap, vec_table_call_instruction, vec_source} = {20'h0, k[2], k[1], s};
			vec_req = 1'b1;
			@(negedge sys_clk);
			vec_req = 1'b0;
			for (int i = 0; i < 8 && vec_done !== 1'b1; i++) begin
				@(posedge sys_clk);
				#1;
			end
			if (vec_done !== 1'b1) begin
				n_fail++;
				final_report();
			end
			check(vec_target, {4'h0, fm.fbyte(a + 20'h1), fm.fbyte(a)});
		end
	endtask : t_vectors

	// Single bit write of the bank bit, written once after the vector tests
	task automatic t_bank;
		// Bit write: only the masked bit may land, the rest of the data is junk
		@(negedge sys_clk);
		acc_wdata    = 8'hff;
		acc_bit_mask = 8'h01;
		xfer(20'hffffe, WR, 8'h00, 1'b0, 5'h00);
		repeat (2) @(negedge sys_clk);
		check(mirror_bank_bit, 1'b1);
		xfer(20'hffffe, RD, 8'h01, 1'b0, 5'h00);
		xfer(20'hf1234, RD, fm.fbyte(20'h11234), 1'b0, 5'h10);
	endtask : t_bank

	initial begin
		{rstn, boot_swap, acc_valid, acc_fetch, acc_write} = 5'h00;
		{vec_req, vec_table_call_instruction, vec_source} = 8'h00;
		{acc_addr, acc_wdata, acc_bit_mask} = 36'h0;
		repeat (20) @(negedge sys_clk);
		rstn = 1'b1;
		t_regions();
		t_fetch();
		t_vectors();
		t_bank();
		// Reset in mid-run must clear the bank selection again
		@(negedge sys_clk);
		rstn = 1'b0;
		@(negedge sys_clk);
		rstn = 1'b1;
		check(mirror_bank_bit, 1'b0);
		final_report();
	end
endmodule : testbench

//--- vector_fetcher.sv
// Two-byte vector and table-call entry reader, low byte first
`timescale 1ns/1ps
`include "memory_space_decoder_defs.svh"

module vector_fetcher
	import memory_space_decoder_pkg::*;
(
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	// Request
	input  wire logic        start,
	input  wire logic [19:0] entry_addr,
	// Flash byte port
	output logic      [19:0] rd_addr,
	output logic             rd_en,
	input  wire logic [7:0]  rd_data,
	// Result
	output logic      [19:0] target,
	output logic             done
);

	vec_state_e state;
	vec_state_e next_state;
	logic [7:0] low_byte;

	// Sequencing of the two byte reads
	always_comb begin
		next_state = state;
		case (state)
			VEC_IDLE: if (start) next_state = VEC_LOW;
			VEC_LOW:  next_state = VEC_HIGH;
			VEC_HIGH: next_state = VEC_DONE;
			VEC_DONE: next_state = VEC_IDLE;
			default:  next_state = VEC_IDLE;
		endcase
	end

	// Even address first, then the odd one
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state    <= VEC_IDLE;
			rd_addr  <= 20'h00000;
			rd_en    <= 1'b0;
			low_byte <= 8'h00;
			target   <= 20'h00000;
			done     <= 1'b0;
		end else begin
			state <= next_state;
			rd_en <= (state == VEC_IDLE && start) || state == VEC_LOW;
			// Done rises on the same edge as the target capture so the result is ready with it
			done  <= state == VEC_DONE;
			if (state == VEC_IDLE && start)
				rd_addr <= {entry_addr[19:1], 1'b0};
			if (state == VEC_LOW)
				rd_addr <= {rd_addr[19:1], 1'b1};
			if (state == VEC_HIGH)
				low_byte <= rd_data;
			if (state == VEC_DONE)
				target <= {4'h0, rd_data, low_byte};
		end
	end

endmodule : vector_fetcher
